// ### src/ctap_card_t0.v
// Card-side T=0 transport: header intake, procedure bytes, body, GET RESPONSE
`timescale 1ns/1ps
`include "ctap_defs.vh"

// Contract
// R1: Terminal sends body paced by procedure bytes
// R2: Terminal drops command after status-only answer
// R3: Case 4 normal body end answers 61 xx
// R4: Case 4 abnormal body end answers status only
// R5: Terminal GET RESPONSE length at most xx
// R6: Terminal sends GET RESPONSE 00 after warnings
// R7: Other statuses end command, no GET RESPONSE
// R8: GET RESPONSE handled exactly as case 2
// R9: Accepted case 4 header acknowledged with INS
// R10: Short GET RESPONSE: leading bytes, then 61 rest
// R11: Follow-up continues from offset, ends 90 00
// R12: Full GET RESPONSE: C0, data, 90 00
// R13: Case 2 length too big: 6C available
// R14: Terminal resends header with indicated P3
// R15: Exact length: data after INS, then status
// R16: Case 2 short length: data then 61 rest
// R17: Abnormal processing never answers 90 00
// R18: Bad P1/P2 rejected with 6B 00
// R19: Null byte 60 only asks terminal to wait
module ctap_card_t0 #(
	parameter NULL_WAIT = `CTAP_NULL_WAIT_CYC,
	parameter DEPTH     = 256,
	parameter AW        = 8
) (
	input  wire          clk_sys,
	input  wire          rst,
	input  wire          rx_valid,
	input  wire [7:0]    rx_byte,
	input  wire          tx_ready,
	output wire          tx_valid,
	output wire [7:0]    tx_byte,
	output wire          hdr_valid,
	output wire [7:0]    hdr_cla,
	output wire [7:0]    hdr_ins,
	output wire [7:0]    hdr_p1,
	output wire [7:0]    hdr_p2,
	output wire [7:0]    hdr_p3,
	output wire          body_valid,
	output wire [7:0]    body_byte,
	output wire          body_done,
	input  wire          dec_valid,
	input  wire          dec_param_ok,
	input  wire          dec_case4,
	input  wire          dec_normal,
	input  wire [7:0]    dec_sw1,
	input  wire [7:0]    dec_sw2,
	input  wire [8:0]    dec_len,
	input  wire          resp_we,
	input  wire [AW-1:0] resp_waddr,
	input  wire [7:0]    resp_wdata,
	output wire          busy
);
	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	localparam [3:0] S_HDR  = 4'h0;
	localparam [3:0] S_DEC  = 4'h1;
	localparam [3:0] S_PROC = 4'h2;
	localparam [3:0] S_BODY = 4'h3;
	localparam [3:0] S_DEC4 = 4'h4;
	localparam [3:0] S_DATA = 4'h5;
	localparam [3:0] S_SW1  = 4'h6;
	localparam [3:0] S_SW2  = 4'h7;
	localparam [3:0] S_NULL = 4'h8;
	localparam [3:0] S_GR   = 4'h9;
	localparam integer WAIT_LAST_I = NULL_WAIT - 1;
	localparam [15:0]  WAIT_LAST   = WAIT_LAST_I[15:0];   // Null wait count must fit the 16-bit timer

	reg  [3:0]  state_reg;
	reg  [2:0]  hcnt_reg;
	reg  [7:0]  cla_reg;
	reg  [7:0]  ins_reg;
	reg  [7:0]  p1_reg;
	reg  [7:0]  p2_reg;
	reg  [7:0]  p3_reg;
	reg         hdr_valid_reg;
	reg         body_valid_reg;
	reg  [7:0]  body_byte_reg;
	reg         body_done_reg;
	reg         tx_valid_reg;
	reg  [7:0]  tx_byte_reg;
	reg  [7:0]  sw1_reg;
	reg  [7:0]  sw2_reg;
	reg  [8:0]  avail_reg;
	reg  [8:0]  offset_reg;
	reg  [8:0]  xfer_reg;
	reg  [8:0]  idx_reg;
	reg         pend_reg;
	reg         to_body_reg;
	reg         ret4_reg;
	reg  [15:0] wait_reg;
	reg         busy_reg;
	reg  [7:0]  tx_pick;
	wire [7:0]  mem_rdata;
	wire [8:0]  le_val;
	wire [AW-1:0] mem_raddr;
	wire        tx_done;
	wire        dec_is_ok;

	assign le_val    = (p3_reg == 8'h00) ? `CTAP_LE_MAX : {1'b0, p3_reg};
	assign mem_raddr = offset_reg[AW-1:0] + idx_reg[AW-1:0];
	assign tx_done   = tx_valid_reg & tx_ready;
	assign dec_is_ok = (dec_sw1 == `CTAP_SW1_OK) && (dec_sw2 == `CTAP_SW2_OK);

	ctap_resp_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
		.clk_sys (clk_sys),
		.we      (resp_we),
		.waddr   (resp_waddr),
		.wdata   (resp_wdata),
		.raddr   (mem_raddr),
		.rdata   (mem_rdata)
	);

	// ------------------------------------------------------------
	// Transmit byte selection
	// ------------------------------------------------------------
	// Byte offered in each sending state
	always @* begin
		case (state_reg)
			S_PROC:  tx_pick = ins_reg;                 // see R9, see R12, see R15
			S_DATA:  tx_pick = mem_rdata;
			S_SW1:   tx_pick = sw1_reg;
			S_SW2:   tx_pick = sw2_reg;
			S_NULL:  tx_pick = `CTAP_PB_NULL;           // see R19
			default: tx_pick = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// Main sequencer
	// ------------------------------------------------------------
	// Sending states hold tx_valid until the serializer takes the byte
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg      <= S_HDR;
			hcnt_reg       <= 3'h0;
			cla_reg        <= 8'h00;
			ins_reg        <= 8'h00;
			p1_reg         <= 8'h00;
			p2_reg         <= 8'h00;
			p3_reg         <= 8'h00;
			hdr_valid_reg  <= 1'b0;
			body_valid_reg <= 1'b0;
			body_byte_reg  <= 8'h00;
			body_done_reg  <= 1'b0;
			tx_valid_reg   <= 1'b0;
			tx_byte_reg    <= 8'h00;
			sw1_reg        <= 8'h00;
			sw2_reg        <= 8'h00;
			avail_reg      <= 9'h000;
			offset_reg     <= 9'h000;
			xfer_reg       <= 9'h000;
			idx_reg        <= 9'h000;
			pend_reg       <= 1'b0;
			to_body_reg    <= 1'b0;
			ret4_reg       <= 1'b0;
			wait_reg       <= 16'h0000;
			busy_reg       <= 1'b0;
		end else begin
			hdr_valid_reg  <= 1'b0;
			body_valid_reg <= 1'b0;
			body_done_reg  <= 1'b0;
			busy_reg       <= (state_reg != S_HDR);
			// Shared transmit handshake
			if (state_reg == S_PROC || state_reg == S_DATA || state_reg == S_SW1 ||
				state_reg == S_SW2 || state_reg == S_NULL) begin
				if (!tx_valid_reg) begin
					tx_valid_reg <= 1'b1;
					tx_byte_reg  <= tx_pick;
				end else if (tx_ready) begin
					tx_valid_reg <= 1'b0;
				end
			end
			case (state_reg)
				// Five header bytes; GET RESPONSE is served here, not by the application
				S_HDR: begin
					if (rx_valid) begin
						hcnt_reg <= hcnt_reg + 3'h1;
						case (hcnt_reg)
							`CTAP_HDR_CLA: cla_reg <= rx_byte;
							`CTAP_HDR_INS: ins_reg <= rx_byte;
							`CTAP_HDR_P1:  p1_reg  <= rx_byte;
							`CTAP_HDR_P2:  p2_reg  <= rx_byte;
							default:       p3_reg  <= rx_byte;
						endcase
						if (hcnt_reg == `CTAP_HDR_P3) begin
							hcnt_reg <= 3'h0;
							wait_reg <= 16'h0000;
							if (ins_reg == `CTAP_INS_GETRESP) begin
								if (pend_reg) begin
									state_reg <= S_GR;   // see R8
								end else begin
									sw1_reg   <= `CTAP_SW1_NOPEND;
									sw2_reg   <= `CTAP_SW2_NOPEND;
									state_reg <= S_SW1;
								end
							end else begin
								pend_reg      <= 1'b0;
								hdr_valid_reg <= 1'b1;
								state_reg     <= S_DEC;
							end
						end
					end
				end
				// Application verdict on the header
				S_DEC: begin
					wait_reg <= wait_reg + 16'h0001;
					if (dec_valid) begin
						if (!dec_param_ok) begin
							sw1_reg   <= `CTAP_SW1_BADP;         // see R18
							sw2_reg   <= `CTAP_SW2_BADP;
							state_reg <= S_SW1;
						end else if (!dec_normal) begin
							// A claimed 90 00 on failure is replaced by a generic error
							sw1_reg   <= dec_is_ok ? `CTAP_SW1_GENERR : dec_sw1; // see R17
							sw2_reg   <= dec_is_ok ? `CTAP_SW2_GENERR : dec_sw2;
							state_reg <= S_SW1;                  // see R2
						end else if (dec_case4) begin
							to_body_reg <= 1'b1;
							idx_reg     <= 9'h000;
							state_reg   <= S_PROC;               // see R9, see R1
						end else begin
							avail_reg  <= dec_len;
							offset_reg <= 9'h000;
							state_reg  <= S_GR;
						end
					end else if (wait_reg == WAIT_LAST) begin
						ret4_reg  <= 1'b0;
						state_reg <= S_NULL;                     // see R19
					end
				end
				// Case 2 length check against what is available
				S_GR: begin
					if (le_val > avail_reg) begin
						sw1_reg   <= `CTAP_PB_WRONGLEN;          // see R13, see R14
						sw2_reg   <= avail_reg[7:0];
						state_reg <= S_SW1;
					end else begin
						to_body_reg <= 1'b0;
						xfer_reg    <= le_val;
						idx_reg     <= 9'h000;
						state_reg   <= S_PROC;                   // see R15
					end
				end
				// Single procedure byte, then the whole transfer in one run
				S_PROC: begin
					if (tx_done) begin
						state_reg <= to_body_reg ? S_BODY : S_DATA;
					end
				end
				// Command body from the terminal
				S_BODY: begin
					if (idx_reg == {1'b0, p3_reg}) begin
						body_done_reg <= 1'b1;
						wait_reg      <= 16'h0000;
						state_reg     <= S_DEC4;
					end else if (rx_valid) begin
						body_valid_reg <= 1'b1;
						body_byte_reg  <= rx_byte;
						idx_reg        <= idx_reg + 9'h001;
					end
				end
				// Outcome of a case 4 body
				S_DEC4: begin
					wait_reg <= wait_reg + 16'h0001;
					if (dec_valid) begin
						if (dec_normal) begin
							pend_reg   <= 1'b1;
							avail_reg  <= dec_len;
							offset_reg <= 9'h000;
							sw1_reg    <= `CTAP_PB_MORE;         // see R3
							sw2_reg    <= dec_len[7:0];
						end else begin
							sw1_reg <= dec_is_ok ? `CTAP_SW1_GENERR : dec_sw1; // see R4, see R17
							sw2_reg <= dec_is_ok ? `CTAP_SW2_GENERR : dec_sw2;
						end
						state_reg <= S_SW1;
					end else if (wait_reg == WAIT_LAST) begin
						ret4_reg  <= 1'b1;
						state_reg <= S_NULL;                     // see R19
					end
				end
				// Response bytes from the stored offset
				S_DATA: begin
					if (tx_done) begin
						idx_reg <= idx_reg + 9'h001;
						if (idx_reg + 9'h001 == xfer_reg) begin
							if (xfer_reg < avail_reg) begin
								pend_reg   <= 1'b1;
								avail_reg  <= avail_reg - xfer_reg;
								offset_reg <= offset_reg + xfer_reg;   // see R11
								sw1_reg    <= `CTAP_PB_MORE;          // see R10, see R16
								sw2_reg    <= avail_reg[7:0] - xfer_reg[7:0];
							end else begin
								pend_reg <= 1'b0;
								sw1_reg  <= `CTAP_SW1_OK;             // see R11, see R12
								sw2_reg  <= `CTAP_SW2_OK;
							end
							state_reg <= S_SW1;
						end
					end
				end
				S_SW1: begin
					if (tx_done) begin
						state_reg <= S_SW2;
					end
				end
				S_SW2: begin
					if (tx_done) begin
						state_reg <= S_HDR;
					end
				end
				// Null byte keeps the terminal waiting; the command carries on
				S_NULL: begin
					if (tx_done) begin
						wait_reg  <= 16'h0000;
						state_reg <= ret4_reg ? S_DEC4 : S_DEC;
					end
				end
				default: begin
					state_reg <= S_HDR;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign tx_valid   = tx_valid_reg;
	assign tx_byte    = tx_byte_reg;
	assign hdr_valid  = hdr_valid_reg;
	assign hdr_cla    = cla_reg;
	assign hdr_ins    = ins_reg;
	assign hdr_p1     = p1_reg;
	assign hdr_p2     = p2_reg;
	assign hdr_p3     = p3_reg;
	assign body_valid = body_valid_reg;
	assign body_byte  = body_byte_reg;
	assign body_done  = body_done_reg;
	assign busy       = busy_reg;
endmodule

// ### src/ctap_defs.vh
// Byte codes, status words and timing constants of the card-side T=0 transport
`ifndef CTAP_DEFS_VH
`define CTAP_DEFS_VH

// ------------------------------------------------------------
// Header field positions (byte index within the 5-byte header)
// ------------------------------------------------------------
`define CTAP_HDR_CLA       3'h0
`define CTAP_HDR_INS       3'h1
`define CTAP_HDR_P1        3'h2
`define CTAP_HDR_P2        3'h3
`define CTAP_HDR_P3        3'h4

// ------------------------------------------------------------
// Procedure bytes and status words
// ------------------------------------------------------------
`define CTAP_INS_GETRESP   8'hC0
`define CTAP_PB_NULL       8'h60
`define CTAP_PB_MORE       8'h61
`define CTAP_PB_WRONGLEN   8'h6C
`define CTAP_SW1_BADP      8'h6B
`define CTAP_SW2_BADP      8'h00
`define CTAP_SW1_OK        8'h90
`define CTAP_SW2_OK        8'h00
`define CTAP_SW1_NOPEND    8'h69
`define CTAP_SW2_NOPEND    8'h85
`define CTAP_SW1_GENERR    8'h6F
`define CTAP_SW2_GENERR    8'h00

// ------------------------------------------------------------
// Lengths and timing
// ------------------------------------------------------------
`define CTAP_LE_MAX        9'h100
`define CTAP_CLK_MHZ       50
`define CTAP_NULL_WAIT_US  20
`define CTAP_NULL_WAIT_CYC (`CTAP_NULL_WAIT_US * `CTAP_CLK_MHZ)

`endif

// ### src/ctap_resp_mem.v
// Response data store written by the application, read by the transport
`timescale 1ns/1ps

module ctap_resp_mem #(
	parameter DEPTH = 256,
	parameter AW    = 8
) (
	input  wire          clk_sys,
	input  wire          we,
	input  wire [AW-1:0] waddr,
	input  wire [7:0]    wdata,
	input  wire [AW-1:0] raddr,
	output wire [7:0]    rdata
);
	reg [7:0] mem [0:DEPTH-1];

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	// Write port; no reset since contents are only read after being written
	always @(posedge clk_sys) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read is combinational so the transmit path needs no extra wait state
	assign rdata = mem[raddr];
endmodule

// ### test/ctap_card_t0_sva.sv
// Assertion checker for the card-side T=0 transport
`timescale 1ns/1ps
module ctap_card_t0_sva #(
	parameter NULL_WAIT = 1000
) (
	input wire       clk_sys,
	input wire       rst,
	input wire       tx_ready,
	input wire       tx_valid,
	input wire [7:0] tx_byte,
	input wire       hdr_valid,
	input wire [7:0] hdr_ins,
	input wire       body_done,
	input wire       dec_valid,
	input wire       dec_param_ok,
	input wire       dec_case4,
	input wire       dec_normal,
	input wire       busy
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------
	// Verdict tracking
	// ------------------------------------------------------------
	// Wait timer runs only while a verdict is owed and nothing is offered
	reg        pend_reg;
	reg        body_reg;
	reg [15:0] wait_reg;
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pend_reg <= 1'b0;
			body_reg <= 1'b0;
			wait_reg <= 16'h0000;
		end else begin
			pend_reg <= dec_valid ? 1'b0 : (hdr_valid | body_done | pend_reg);
			body_reg <= dec_valid ? 1'b0 : (body_done | body_reg);
			wait_reg <= (pend_reg && !tx_valid) ? wait_reg + 16'h0001 : 16'h0000;
		end
	end
	rst_idle_a: assert property ($fell(rst) |-> !tx_valid && !busy && !hdr_valid)
		else $error("output active after reset");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
		else $error("card byte dropped or changed");
	tx_gap_a: assert property (tx_valid && tx_ready |=> !tx_valid)
		else $error("no idle cycle after byte");
	bad_param_a: assert property (dec_valid && !dec_param_ok && !body_reg && !tx_valid |->
		##[1:2] tx_valid && tx_byte == 8'h6B) else $error("bad parameters not rejected");
	case4_ack_a: assert property (dec_valid && !body_reg && dec_param_ok && dec_case4 && dec_normal &&
		!tx_valid |-> ##[1:2] tx_valid && tx_byte == hdr_ins) else $error("no echo of instruction");
	body_more_a: assert property (dec_valid && body_reg && dec_normal && !tx_valid |->
		##[1:2] tx_valid && tx_byte == 8'h61) else $error("no 61 after body");
	abn_status_a: assert property (dec_valid && pend_reg && dec_param_ok && !dec_normal && !tx_valid |->
		##[1:2] tx_valid && tx_byte != 8'h90 && tx_byte != 8'h61) else $error("abnormal gave normal answer");
	null_byte_a: assert property (pend_reg && $rose(tx_valid) |-> tx_byte == 8'h60)
		else $error("wrong byte while waiting");
	null_wait_a: assert property (pend_reg |-> wait_reg < NULL_WAIT + 4)
		else $error("no null byte in time");
	cover property (body_reg && dec_valid);
	cover property (tx_valid && tx_byte == 8'h60);
	cover property (tx_valid && tx_byte == 8'h6C);
endmodule
bind ctap_card_t0 ctap_card_t0_sva #(.NULL_WAIT(NULL_WAIT)) ctap_card_t0_sva_inst (
	.clk_sys(clk_sys), .rst(rst), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte),
	.hdr_valid(hdr_valid), .hdr_ins(hdr_ins), .body_done(body_done), .dec_valid(dec_valid),
	.dec_param_ok(dec_param_ok), .dec_case4(dec_case4), .dec_normal(dec_normal), .busy(busy)
);

// ### test/ctap_term_model.sv
// Terminal transport model: sends link bytes, takes card bytes with stalls
`timescale 1ns/1ps
module ctap_term_model (
	input  wire       clk_sys,
	input  wire       tx_valid,
	input  wire [7:0] tx_byte,
	output reg        tx_ready,
	output reg        rx_valid,
	output reg  [7:0] rx_byte
);
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_byte  = 8'h00;
	end
	// One strobe per byte; line scrambled after so a stale value never passes
	task send_byte(input [7:0] b);
		begin
			@(posedge clk_sys);
			rx_valid <= 1'b1;
			rx_byte  <= b;
			@(posedge clk_sys);
			rx_valid <= 1'b0;
			rx_byte  <= ~b;
		end
	endtask
	// Random stall before accepting; X returned if the card never offers
	task get_byte(output [7:0] b);
		integer n;
		begin
			b = 8'hXX;
			n = 0;
			repeat (1 + $urandom_range(2)) @(posedge clk_sys);
			tx_ready <= 1'b1;
			@(posedge clk_sys);
			while (!(tx_valid === 1'b1 && tx_ready === 1'b1) && n < 3000) begin
				@(posedge clk_sys);
				n = n + 1;
			end
			if (n < 3000)
				b = tx_byte;
			tx_ready <= 1'b0;
		end
	endtask
endmodule

// ### test/card_t0_apdu_transport_bench.sv
// Self-checking bench: random commands through a terminal model
`timescale 1ns/1ps
module card_t0_apdu_transport_bench;
	reg        clk_sys = 1'b0;
	reg        rst = 1'b1;
	reg        dec_valid = 1'b0;
	reg        dec_param_ok = 1'b0;
	reg        dec_case4 = 1'b0;
	reg        dec_normal = 1'b0;
	reg  [7:0] dec_sw1 = 8'h00;
	reg  [7:0] dec_sw2 = 8'h00;
	reg  [8:0] dec_len = 9'h000;
	reg        resp_we = 1'b0;
	reg  [7:0] resp_waddr = 8'h00;
	reg  [7:0] resp_wdata = 8'h00;
	wire       rx_valid, tx_ready, tx_valid, hdr_valid, body_valid, body_done, busy;
	wire [7:0] rx_byte, tx_byte, hdr_p3, body_byte, hdr_cla, hdr_ins, hdr_p1, hdr_p2;
	reg  [7:0] mem [0:255];
	reg  [7:0] bq [$];
	reg [15:0] sw_tab [0:2] = '{16'h9000, 16'h6A82, 16'h6283};
	integer    mismatches = 0;
	integer    n_tests = 0;
	integer    i, k, len, yy, seed;
	always #10 clk_sys = ~clk_sys;
	ctap_card_t0 #(.NULL_WAIT(20)) ctap_card_t0_inst (
		.clk_sys(clk_sys), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_ready(tx_ready),
		.tx_valid(tx_valid), .tx_byte(tx_byte), .hdr_valid(hdr_valid), .hdr_cla(hdr_cla), .hdr_ins(hdr_ins),
		.hdr_p1(hdr_p1), .hdr_p2(hdr_p2), .hdr_p3(hdr_p3), .body_valid(body_valid), .body_byte(body_byte),
		.body_done(body_done), .dec_valid(dec_valid), .dec_param_ok(dec_param_ok), .dec_case4(dec_case4),
		.dec_normal(dec_normal), .dec_sw1(dec_sw1), .dec_sw2(dec_sw2), .dec_len(dec_len),
		.resp_we(resp_we), .resp_waddr(resp_waddr), .resp_wdata(resp_wdata), .busy(busy));
	ctap_term_model ctap_term_model_inst (.clk_sys(clk_sys), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte));
	// Body bytes are pulses, so collect them as they pass
	always @(posedge clk_sys) if (body_valid === 1'b1) bq.push_back(body_byte);
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task chk(input [7:0] got, input [7:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("ERROR %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task expb(input [7:0] e);
		reg [7:0] g;
		begin
			ctap_term_model_inst.get_byte(g);
			chk(g, e);
		end
	endtask
	task data(input integer off, input integer n);
		for (k = 0; k < n; k = k + 1) expb(mem[off + k]);
	endtask
	// GET RESPONSE is served inside the card, so no header strobe is awaited
	task hdr(input [7:0] ins, input [7:0] p3);
		integer n;
		reg [7:0] c, a, b;
		begin
			c = 8'($urandom);
			a = 8'($urandom);
			b = 8'($urandom);
			ctap_term_model_inst.send_byte(c);
			ctap_term_model_inst.send_byte(ins);
			ctap_term_model_inst.send_byte(a);
			ctap_term_model_inst.send_byte(b);
			ctap_term_model_inst.send_byte(p3);
			n = 0;
			while (ins != 8'hC0 && hdr_valid !== 1'b1 && n < 20) begin
				@(posedge clk_sys);
				n = n + 1;
			end
			// Every header field must reach the application, and the strobe must come
			if (ins != 8'hC0) begin
				chk({7'h00, hdr_valid}, 8'h01);
				chk(hdr_p3, p3);
				chk(hdr_cla, c);
				chk(hdr_ins, ins);
				chk(hdr_p1, a);
				chk(hdr_p2, b);
			end
		end
	endtask
	task verdict(input pok, input c4, input nrm, input [7:0] s1, input [7:0] s2, input [8:0] ln);
		begin
			dec_param_ok <= pok;
			dec_case4 <= c4;
			dec_normal <= nrm;
			dec_sw1 <= s1;
			dec_sw2 <= s2;
			dec_len <= ln;
			dec_valid <= 1'b1;
			@(posedge clk_sys);
			dec_valid <= 1'b0;
			chk({7'h00, busy}, 8'h01);
		end
	endtask
	task load(input integer n);
		begin
			for (k = 0; k < n; k = k + 1) begin
				@(posedge clk_sys);
				mem[k] = 8'($urandom);
				resp_we <= 1'b1;
				resp_waddr <= 8'(k);
				resp_wdata <= mem[k];
			end
			@(posedge clk_sys);
			resp_we <= 1'b0;
			chk({7'h00, busy}, 8'h00);
		end
	endtask
	task body(input integer n);
		reg [7:0] b0;
		integer m;
		begin
			b0 = 8'($urandom);
			bq.delete();
			for (m = 0; m < n; m = m + 1) ctap_term_model_inst.send_byte(b0 + 8'(m));
			m = 0;
			while (body_done !== 1'b1 && m < 20) begin
				@(posedge clk_sys);
				m = m + 1;
			end
			@(posedge clk_sys);
			chk(8'(bq.size()), 8'(n));
			for (m = 0; m < n; m = m + 1) chk(bq[m], b0 + 8'(m));
		end
	endtask
	task finish_test;
		begin
			$display("mismatches=%0d checks=%0d", mismatches, n_tests);
			if (mismatches == 0 && n_tests > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		seed = $urandom(74);
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		load(11);
		hdr(8'hB0, 8'h0B);
		verdict(1'b0, 1'b0, 1'b1, 8'h00, 8'h00, 9'h00B);
		expb(8'h6B);
		expb(8'h00);
		// Length 00 or too long draws 6C; header then resent with that length
		for (i = 0; i < 3; i = i + 1) begin
			hdr(8'hB0, (i == 0) ? 8'h00 : 8'(12 + $urandom_range(200)));
			verdict(1'b1, 1'b0, 1'b1, 8'h00, 8'h00, 9'h00B);
			expb(8'h6C);
			expb(8'h0B);
			hdr(8'hB0, 8'h0B);
			verdict(1'b1, 1'b0, 1'b1, 8'h00, 8'h00, 9'h00B);
			expb(8'hB0);
			data(0, 11);
			expb(8'h90);
			expb(8'h00);
		end
		// Abnormal verdicts, one claiming normal completion
		for (i = 0; i < 3; i = i + 1) begin
			hdr(8'hB0, 8'($urandom));
			verdict(1'b1, 1'b0, 1'b0, sw_tab[i][15:8], sw_tab[i][7:0], 9'h00B);
			expb((i == 0) ? 8'h6F : sw_tab[i][15:8]);
			expb(sw_tab[i][7:0]);
		end
		// Case 4: split retrieval first, then one full-length retrieval; last pass is a short case 2 read finished by GET RESPONSE
		for (i = 0; i < 3; i = i + 1) begin
			len = 12 + $urandom_range(40);
			load(len);
			if (i == 2) begin
				yy = len;
				hdr(8'hB0, 8'h05);
			end else begin
				hdr(8'hA4, 8'h02);
				verdict(1'b1, 1'b1, 1'b1, 8'h00, 8'h00, 9'h000);
				expb(8'hA4);
				body(2);
				yy = (i == 0) ? 1 + $urandom_range(len - 2) : len;
			end
			verdict(1'b1, 1'b0, 1'b1, 8'h00, 8'h00, 9'(len));
			if (i == 2) begin
				expb(8'hB0);
				data(0, 5);
				yy = 5;
			end else begin
				expb(8'h61);
				expb(8'(len));
				// Over-long retrieval first draws 6C; the pending data must survive it
				if (i == 1) begin
					hdr(8'hC0, 8'(len + 1));
					expb(8'h6C);
					expb(8'(len));
				end
				hdr(8'hC0, 8'(yy));
				expb(8'hC0);
				data(0, yy);
			end
			if (i != 1) begin
				expb(8'h61);
				expb(8'(len - yy));
				hdr(8'hC0, 8'(len - yy));
				expb(8'hC0);
				data(yy, len - yy);
			end
			expb(8'h90);
			expb(8'h00);
		end
		// Case 4 failure claiming 90 00: generic error, and the terminal stops there
		hdr(8'hA4, 8'h01);
		verdict(1'b1, 1'b1, 1'b1, 8'h00, 8'h00, 9'h000);
		expb(8'hA4);
		body(1);
		verdict(1'b1, 1'b0, 1'b0, 8'h90, 8'h00, 9'h000);
		expb(8'h6F);
		expb(8'h00);
		// Case 4 warning: status only, then GET RESPONSE 00 with nothing held
		hdr(8'hA4, 8'h01);
		verdict(1'b1, 1'b1, 1'b1, 8'h00, 8'h00, 9'h000);
		expb(8'hA4);
		body(1);
		verdict(1'b1, 1'b0, 1'b0, 8'h63, 8'hC1, 9'h000);
		expb(8'h63);
		expb(8'hC1);
		hdr(8'hC0, 8'h00);
		expb(8'h69);
		expb(8'h85);
		// Slow verdict: null byte first, then the normal answer
		hdr(8'hB0, 8'h05);
		expb(8'h60);
		repeat (2) @(posedge clk_sys);
		verdict(1'b1, 1'b0, 1'b1, 8'h00, 8'h00, 9'(len));
		expb(8'hB0);
		data(0, 5);
		expb(8'h61);
		expb(8'(len - 5));
		// Full 256-byte transfer asked for with length 00
		load(256);
		hdr(8'hB0, 8'h00);
		verdict(1'b1, 1'b0, 1'b1, 8'h00, 8'h00, 9'h100);
		expb(8'hB0);
		data(0, 256);
		expb(8'h90);
		expb(8'h00);
		finish_test;
	end
	// Whole run needs well under 20k cycles
	initial begin
		#400000;
		mismatches = mismatches + 1;
		$display("ERROR %0t: watchdog expired", $time);
		finish_test;
	end
endmodule
